// [hw/scpr_chan_route.sv]
`default_nettype none

module scpr_chan_route
  import scpr_pkg::*;
(
  // Channel settings and derived pin roles.
  scpr_chan_if.route bus
);

  logic clocked;
  logic async_kind;
  logic twowire;

  // Pin roles of one clocked-serial/async/two-wire channel.
  always_comb
  begin
    clocked    = (bus.kind == SCPR_CLOCKED);
    async_kind = (bus.kind == SCPR_ASYNC);
    twowire    = (bus.kind == SCPR_TWOWIRE);
    // The two-wire clock level stays on the pin while stopped for start and stop.
    // Same path serves the stop condition.
    bus.clk_func  = (bus.running & clocked) | twowire;
    // Serial level reaches the pin only with output enable.
    bus.dout_func = bus.running & bus.drive_en & bus.tx & (clocked | async_kind);
    // Data line is driven while running with enable, or by hand while stopped.
    bus.din_drive = twowire & (bus.drive_en | ~bus.running);
    bus.din_ser   = bus.running & ((clocked & bus.rx) | twowire);
    // Clocked or two-wire use of the pin clashes with the paired receiver.
    bus.conflict  = bus.partner_rx & bus.running & (clocked | twowire);
  end

endmodule

`default_nettype wire

// [hw/scpr_pin_route.sv]
// Behaviour
// - Running flags change only by start/stop triggers.
// - Stopped or unused pins act as ports, except the two-wire clock and data pins.
// - Running channel levels follow communication activity.
// - Unit 0 channel 3 receive takes shared pin unless a clocked or two-wire owner clashes.
`default_nettype none

module scpr_pin_route
  import scpr_pkg::*;
#(
  parameter int FULL_CHANS = 2
)
(
  // Clock, reset and clock enable.
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  // Run control, one bit per channel.
  input  wire logic [5:0]       start_trigger_reg,
  input  wire logic [5:0]       stop_trigger_reg,
  output logic      [5:0]       channel_running_flag,
  // Channel settings.
  input  wire logic [5:0][1:0]  operating_kind_field,
  input  wire logic [5:0]       transmit_allow,
  input  wire logic [5:0]       receive_allow,
  input  wire logic [2:0]       out_drive_enable,
  input  wire logic [2:0]       serial_out_level,
  input  wire logic [1:0]       clock_out_level,
  // Port direction and latch bits, one per pin.
  input  wire logic [7:0]       pin_direction_bit,
  input  wire logic [7:0]       port_latch_bit,
  // Pins.
  input  wire logic [7:0]       pin_in,
  output logic      [7:0]       pin_out,
  output logic      [7:0]       pin_oe,
  // Routed inputs to the shifters and status.
  output logic      [1:0]       ser_clock_in,
  output logic      [1:0]       ser_data_in,
  output logic      [2:0]       uart_rx_in,
  output logic      [7:0]       pin_is_port,
  output logic      [1:0]       rx_conflict
);

  if (FULL_CHANS != 2)
  begin : g_bad_count
    $error("scpr_pin_route serves exactly two three-pin channels");
  end

  // Port latch gates the function level, so a one in the latch lets it through.
  function automatic logic pin_level(input logic latch, input logic func, input logic lvl);
    pin_level = latch & (func ? lvl : 1'b1);
  endfunction

  function automatic logic rx_only(input logic [1:0] kind, input logic tx, input logic rx);
    rx_only = (kind == SCPR_ASYNC) & rx & ~tx;
  endfunction

  scpr_state_t state_reg;
  scpr_state_t state_next;
  logic [1:0]  clk_func;
  logic [1:0]  dout_func;
  logic [1:0]  din_drive;
  logic [1:0]  din_ser;
  logic [1:0]  conflict;
  logic [1:0]  partner_rx;

  // One router per three-pin channel; its paired receiver sits one index above.
  for (genvar i = 0; i < FULL_CHANS; i++)
  begin : g_chan
    localparam int CI = 2 * i;
    scpr_chan_if ch_if ();
    // Paired receiver active means the shared pin serves receive data.
    assign partner_rx[i] = state_reg.running[CI+1]
                           & rx_only(operating_kind_field[CI+1], transmit_allow[CI+1],
                                     receive_allow[CI+1]);
    assign ch_if.kind       = operating_kind_field[CI];
    assign ch_if.running    = state_reg.running[CI];
    assign ch_if.drive_en   = out_drive_enable[i];
    assign ch_if.tx         = transmit_allow[CI];
    assign ch_if.rx         = receive_allow[CI];
    assign ch_if.partner_rx = partner_rx[i];
    assign clk_func[i]      = ch_if.clk_func;
    assign dout_func[i]     = ch_if.dout_func;
    assign din_drive[i]     = ch_if.din_drive;
    assign din_ser[i]       = ch_if.din_ser;
    assign conflict[i]      = ch_if.conflict;
    scpr_chan_route u_route (
      .bus (ch_if.route)
    );
  end

  // Next state of flags, pins and routed inputs.
  always_comb
  begin
    int   b;
    logic tx_func;
    logic rx3_act;
    b          = 0;
    tx_func    = 1'b0;
    rx3_act    = 1'b0;
    state_next = state_reg;
    // Only the trigger pulses move the running flags; stop wins a tie.
    for (int c = 0; c < 6; c++)
    begin
      if (stop_trigger_reg[c])
        state_next.running[c] = 1'b0;
      else if (start_trigger_reg[c])
        state_next.running[c] = 1'b1;
    end
    // Output enable follows the direction bit, so ports keep working.
    state_next.pin_oe = ~pin_direction_bit;
    for (int i = 0; i < 2; i++)
    begin
      b = i * `SCPR_PINS_PER_CH;
      // Clock and data levels come from the live shifter bits, gated by the port latch.
      state_next.pin_out[b + `SCPR_PIN_CLK] =
        pin_level(port_latch_bit[b + `SCPR_PIN_CLK], clk_func[i], clock_out_level[i]);
      state_next.pin_out[b + `SCPR_PIN_DIN] =
        pin_level(port_latch_bit[b + `SCPR_PIN_DIN], din_drive[i], serial_out_level[i]);
      state_next.pin_out[b + `SCPR_PIN_DOUT] =
        pin_level(port_latch_bit[b + `SCPR_PIN_DOUT], dout_func[i], serial_out_level[i]);
      // A pin no function claims is a general port.
      state_next.pin_is_port[b + `SCPR_PIN_CLK]  = ~clk_func[i];
      state_next.pin_is_port[b + `SCPR_PIN_DIN]  = ~(din_drive[i] | din_ser[i] | partner_rx[i]);
      state_next.pin_is_port[b + `SCPR_PIN_DOUT] = ~dout_func[i];
      state_next.ser_clock_in[i] = pin_in[b + `SCPR_PIN_CLK];
      // Idle-high inputs keep a shifter quiet when its pin is elsewhere.
      state_next.ser_data_in[i] = din_ser[i] ? pin_in[b + `SCPR_PIN_DIN] : 1'b1;
      // Receive data taken only while the paired channel runs async with receive allowed and transmit not allowed.
      // A clocked or two-wire owner blocks the receiver.
      state_next.uart_rx_in[i] = (partner_rx[i] & ~conflict[i]) ? pin_in[b + `SCPR_PIN_DIN]
                                                                 : 1'b1;
      state_next.rx_conflict[i] = conflict[i];
    end
    // The last pair offers only async transmit and receive.
    tx_func = state_reg.running[`SCPR_CH_U1C2] & out_drive_enable[2]
              & (operating_kind_field[`SCPR_CH_U1C2] == SCPR_ASYNC)
              & transmit_allow[`SCPR_CH_U1C2];
    rx3_act = state_reg.running[`SCPR_CH_U1C3]
              & rx_only(operating_kind_field[`SCPR_CH_U1C3], transmit_allow[`SCPR_CH_U1C3],
                        receive_allow[`SCPR_CH_U1C3]);
    // The transmit pin carries the serial level only with output enable.
    state_next.pin_out[`SCPR_PIN_U1C2_TX] =
      pin_level(port_latch_bit[`SCPR_PIN_U1C2_TX], tx_func, serial_out_level[2]);
    state_next.pin_out[`SCPR_PIN_U1C3_RX] = port_latch_bit[`SCPR_PIN_U1C3_RX];
    state_next.pin_is_port[`SCPR_PIN_U1C2_TX] = ~tx_func;
    state_next.pin_is_port[`SCPR_PIN_U1C3_RX] = ~rx3_act;
    state_next.uart_rx_in[2] = rx3_act ? pin_in[`SCPR_PIN_U1C3_RX] : 1'b1;
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg.running      <= `SCPR_RST_RUNNING;
      state_reg.pin_out      <= `SCPR_RST_PIN_OUT;
      state_reg.pin_oe       <= `SCPR_RST_PIN_OE;
      state_reg.pin_is_port  <= `SCPR_RST_IS_PORT;
      state_reg.ser_clock_in <= `SCPR_RST_SER_IN;
      state_reg.ser_data_in  <= `SCPR_RST_SER_IN;
      state_reg.uart_rx_in   <= `SCPR_RST_RX_IN;
      state_reg.rx_conflict  <= `SCPR_RST_CONFLICT;
    end
    else if (ce)
      state_reg <= state_next;
  end

  // Outputs all come from the state register.
  assign channel_running_flag = state_reg.running;
  assign pin_out              = state_reg.pin_out;
  assign pin_oe               = state_reg.pin_oe;
  assign pin_is_port          = state_reg.pin_is_port;
  assign ser_clock_in         = state_reg.ser_clock_in;
  assign ser_data_in          = state_reg.ser_data_in;
  assign uart_rx_in           = state_reg.uart_rx_in;
  assign rx_conflict          = state_reg.rx_conflict;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  run_hold_a: assert property (
    (!ce || (start_trigger_reg == 6'h00 && stop_trigger_reg == 6'h00))
    |=> $stable(channel_running_flag))
    else $error("running flag moved without a trigger");
  run_start_a: assert property (
    ce && start_trigger_reg[0] && !stop_trigger_reg[0] |=> channel_running_flag[0])
    else $error("start trigger did not set the flag");
  oe_dir_a: assert property (
    ce |=> pin_oe == ~$past(pin_direction_bit))
    else $error("output enable does not follow direction");
  stopped_port_a: assert property (
    ce && !channel_running_flag[4] |=> pin_out[6] == $past(port_latch_bit[6])
                                       && pin_is_port[6])
    else $error("stopped transmit pin not a port");
  tx_level_a: assert property (
    ce && channel_running_flag[4] && out_drive_enable[2] && transmit_allow[4]
    && operating_kind_field[4] == SCPR_ASYNC
    |=> pin_out[6] == ($past(port_latch_bit[6]) & $past(serial_out_level[2])))
    else $error("transmit pin does not follow the serial level");
  no_drive_a: assert property (
    ce && !out_drive_enable[0] && operating_kind_field[0] != SCPR_TWOWIRE
    |=> pin_out[2] == $past(port_latch_bit[2]))
    else $error("serial level reached a pin without enable");
  rx_route_a: assert property (
    ce && partner_rx[0] && !conflict[0] |=> uart_rx_in[0] == $past(pin_in[1]))
    // A frozen cycle keeps the old receive level, so only enabled cycles are judged.
    else $error("receive data not taken from the shared pin");
  clash_a: assert property (
    ce && channel_running_flag[0] && channel_running_flag[1]
    && operating_kind_field[0] == SCPR_CLOCKED && rx_only(operating_kind_field[1],
    transmit_allow[1], receive_allow[1]) |=> rx_conflict[0] && uart_rx_in[0])
    else $error("clash not flagged or receive data leaked");
  tw_clock_a: assert property (
    ce && operating_kind_field[0] == SCPR_TWOWIRE
    |=> pin_out[0] == ($past(port_latch_bit[0]) & $past(clock_out_level[0])))
    else $error("two-wire clock level not on its pin");

endmodule

`default_nettype wire

// [inc/scpr_chan_if.sv]
`default_nettype none

// Settings of one three-pin channel and the pin roles derived from them.
interface scpr_chan_if;
  logic [1:0] kind;
  logic       running;
  logic       drive_en;
  logic       tx;
  logic       rx;
  logic       partner_rx;
  logic       clk_func;
  logic       dout_func;
  logic       din_drive;
  logic       din_ser;
  logic       conflict;

  modport route (
    input  kind, running, drive_en, tx, rx, partner_rx,
    output clk_func, dout_func, din_drive, din_ser, conflict
  );
  modport top (
    output kind, running, drive_en, tx, rx, partner_rx,
    input  clk_func, dout_func, din_drive, din_ser, conflict
  );
endinterface

`default_nettype wire

// [inc/scpr_map.svh]
`ifndef SCPR_MAP_SVH
`define SCPR_MAP_SVH

// Operating kind field encodings.
`define SCPR_KIND_CLOCKED   2'h0
`define SCPR_KIND_ASYNC     2'h1
`define SCPR_KIND_TWOWIRE   2'h2

// Channel positions in the running flag vector.
`define SCPR_CH_U0C2        0
`define SCPR_CH_U0C3        1
`define SCPR_CH_U1C0        2
`define SCPR_CH_U1C1        3
`define SCPR_CH_U1C2        4
`define SCPR_CH_U1C3        5

// Pin positions; the three-pin channels use base, base+1, base+2.
`define SCPR_PIN_CLK        0
`define SCPR_PIN_DIN        1
`define SCPR_PIN_DOUT       2
`define SCPR_PINS_PER_CH    3
`define SCPR_PIN_U1C2_TX    6
`define SCPR_PIN_U1C3_RX    7

// Reset values of the registered state.
`define SCPR_RST_RUNNING    6'h00
`define SCPR_RST_PIN_OUT    8'hff
`define SCPR_RST_PIN_OE     8'h00
`define SCPR_RST_IS_PORT    8'hff
`define SCPR_RST_SER_IN     2'h3
`define SCPR_RST_RX_IN      3'h7
`define SCPR_RST_CONFLICT   2'h0

`endif

// [inc/scpr_pkg.sv]
`default_nettype none
`include "scpr_map.svh"

package scpr_pkg;

  typedef enum logic [1:0] {
    SCPR_CLOCKED = `SCPR_KIND_CLOCKED,
    SCPR_ASYNC   = `SCPR_KIND_ASYNC,
    SCPR_TWOWIRE = `SCPR_KIND_TWOWIRE
  } scpr_kind_t;

  typedef struct packed {
    logic [5:0] running;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pin_is_port;
    logic [1:0] ser_clock_in;
    logic [1:0] ser_data_in;
    logic [2:0] uart_rx_in;
    logic [1:0] rx_conflict;
  } scpr_state_t;

endpackage

`default_nettype wire

// [testbench/scpr_far_model.sv]
`default_nettype none

// Far-side serial devices on the shared pins.
module scpr_far_model
(
  // Device side of the pins.
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // What the far side wants to drive.
  input  wire logic [7:0] far_en,
  input  wire logic [7:0] far_val,
  // Resolved wire level.
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // The device wins while it drives; a released line floats up to the pull-up.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (far_en[i] ? far_val[i] : 1'b1);
    end
  end
endmodule

`default_nettype wire

// [testbench/tb_serial_channel_pin_routing.sv]
`default_nettype none

module tb_serial_channel_pin_routing;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk, reset, ce;
  logic [5:0]      st, sp, flag, txa, rxa;
  logic [5:0][1:0] kind;
  logic [2:0]      oen, sol, urx;
  logic [1:0]      col, sclk, sdin, conf;
  logic [7:0]      dir, lat, pin_in, pout, poe, port, far_en, far_val;
  int              failures, samples_checked, cycles;

  scpr_pin_route #(.FULL_CHANS(2)) uut (
    .clk(clk), .reset(reset), .ce(ce), .start_trigger_reg(st), .stop_trigger_reg(sp),
    .channel_running_flag(flag), .operating_kind_field(kind), .transmit_allow(txa),
    .receive_allow(rxa), .out_drive_enable(oen), .serial_out_level(sol),
    .clock_out_level(col), .pin_direction_bit(dir), .port_latch_bit(lat),
    .pin_in(pin_in), .pin_out(pout), .pin_oe(poe), .ser_clock_in(sclk),
    .ser_data_in(sdin), .uart_rx_in(urx), .pin_is_port(port), .rx_conflict(conf));

  scpr_far_model far (.pin_out(pout), .pin_oe(poe), .far_en(far_en),
    .far_val(far_val), .pin_in(pin_in));

  // Clock of 25 ns.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog, so a hung run still reaches the verdict.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One edge to sample the inputs, then let the registers settle.
  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  // Trigger pulse; pins follow one cycle after the flag.
  task automatic set_run(input int ch, input logic on);
    @(posedge clk);
    if (on) st[ch] <= 1'b1;
    else sp[ch] <= 1'b1;
    @(posedge clk);
    st <= 6'h00;
    sp <= 6'h00;
    settle();
  endtask

  task automatic t_run();
    set_run(4, 1'b1);
    check(flag, 8'h10);
    @(posedge clk);
    st <= 6'h10;
    sp <= 6'h10;
    @(posedge clk);
    st <= 6'h00;
    sp <= 6'h00;
    #1;
    check(flag, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    st <= 6'h10;
    @(posedge clk);
    ce <= 1'b1;
    st <= 6'h00;
    settle();
    check(flag, 8'h00);
    $display("test run control done");
  endtask

  task automatic t_tx();
    @(posedge clk);
    kind[4] <= 2'h1;
    txa[4] <= 1'b1;
    oen[2] <= 1'b1;
    sol[2] <= 1'b0;
    kind[5] <= 2'h1;
    rxa[5] <= 1'b1;
    far_en <= 8'h80;
    set_run(4, 1'b1);
    check(pout[6], 8'h00);
    check(port[6], 8'h00);
    set_run(5, 1'b1);
    check({urx[2], port[7], pout[7]}, 8'h01);
    @(posedge clk);
    sol[2] <= 1'b1;
    settle();
    check(pout[6], 8'h01);
    @(posedge clk);
    oen[2] <= 1'b0;
    sol[2] <= 1'b0;
    settle();
    check(pout[6], 8'h01);
    // Enable back on, so only the stop can free the pin.
    @(posedge clk);
    oen[2] <= 1'b1;
    set_run(4, 1'b0);
    check({pout[6], port[6]}, 8'h03);
    $display("test uart transmit done");
  endtask

  task automatic t_csi();
    @(posedge clk);
    {txa[0], rxa[0], oen[0], col[0], sol[0]} <= 5'h1d;
    far_en <= 8'h03;
    far_val <= 8'h00;
    set_run(0, 1'b1);
    check({poe[0], pout[0], pout[2], sdin[0]}, 8'h0a);
    @(posedge clk);
    col[0] <= 1'b1;
    sol[0] <= 1'b0;
    dir[0] <= 1'b1;
    far_val <= 8'h01;
    settle();
    settle();
    check({poe[0], sclk[0], pout[2]}, 8'h02);
    $display("test clocked serial done");
  endtask

  task automatic t_conflict();
    @(posedge clk);
    kind[1] <= 2'h1;
    rxa[1] <= 1'b1;
    dir[1] <= 1'b1;
    set_run(1, 1'b1);
    check({conf[0], urx[0]}, 8'h03);
    set_run(0, 1'b0);
    check({conf[0], urx[0]}, 8'h00);
    // Pair channel 2 transmit, channel 3 receive.
    @(posedge clk);
    // Channel 2 mode set for transmission.
    kind[0] <= 2'h1;
    rxa[0] <= 1'b0;
    far_val <= 8'h02;
    set_run(0, 1'b1);
    check({conf[0], urx[0], pout[2]}, 8'h02);
    set_run(0, 1'b0);
    set_run(1, 1'b0);
    // Unit 1 clocked owner blocks receiver.
    @(posedge clk);
    kind[3] <= 2'h1;
    rxa[3] <= 1'b1;
    set_run(2, 1'b1);
    set_run(3, 1'b1);
    check({conf[1], urx[1], sclk[1]}, 8'h07);
    $display("test shared receive done");
  endtask

  task automatic t_twowire();
    @(posedge clk);
    kind[0] <= 2'h2;
    dir <= 8'h00;
    {col[0], sol[0]} <= 2'h3;
    settle();
    check({pout[0], pout[1]}, 8'h03);
    @(posedge clk);
    sol[0] <= 1'b0;
    settle();
    check({pout[0], pout[1]}, 8'h02);
    @(posedge clk);
    sol[0] <= 1'b1;
    settle();
    check({pout[0], pout[1]}, 8'h03);
    @(posedge clk);
    {oen[0], txa[0], rxa[0], sol[0]} <= 4'hc;
    set_run(0, 1'b1);
    check({pout[1], port[1]}, 8'h00);
    $display("test two-wire done");
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    {reset, ce, st, sp, txa, rxa, oen, sol, col} = {2'h3, 24'h000000, 3'h0, 3'h7, 2'h3};
    kind = '0;
    {dir, lat, far_en, far_val} = {8'hff, 8'hff, 8'h00, 8'h00};
    repeat (10) @(posedge clk);
    #1;
    check({flag, urx[0]}, 8'h01);
    check(pout & ~poe & port, 8'hff);
    @(posedge clk);
    reset <= 1'b0;
    {dir[0], dir[2], dir[6]} <= 3'h0;
    settle();
    t_run();
    t_tx();
    t_csi();
    t_conflict();
    t_twowire();
    final_report();
  end
endmodule

`default_nettype wire
